// [rtl/cdlut_cfg.svh]
// Constants for the colour depth lookup table block.
// Assumes one 100 MHz clock and an already decoded command/data byte stream.
`ifndef CDLUT_CFG_SVH
`define CDLUT_CFG_SVH

`define CDLUT_CMD_LOAD     8'h2d
`define CDLUT_TONES        16
`define CDLUT_LOAD_LAST    6'h2f
`define CDLUT_GREEN_FIRST  6'h10
`define CDLUT_BLUE_FIRST   6'h20
`define CDLUT_FMT_256      3'h2
`define CDLUT_FMT_4096     3'h3
`define CDLUT_KEEP_RG256   4'h7
`define CDLUT_KEEP_B256    4'h3

`endif

// [rtl/cdlut_pkg.sv]
// Types shared by the colour depth lookup table block.
// Assumes cdlut_cfg.svh supplies the numeric constants.
package cdlut_pkg;

  // One byte from the host interface with its command/data flag
  typedef struct packed {
    logic       is_cmd;
    logic [7:0] data;
  } cdlut_byte_type;

  // Reduced-depth pixel codes, right aligned
  typedef struct packed {
    logic [3:0] red;
    logic [3:0] green;
    logic [3:0] blue;
  } cdlut_code_type;

  // Frame memory native pixel
  typedef struct packed {
    logic [4:0] red;
    logic [5:0] green;
    logic [4:0] blue;
  } cdlut_pixel_type;

  typedef enum logic [1:0] {
    CDLUT_IDLE,
    CDLUT_LOADING,
    CDLUT_OTHER
  } cdlut_state_type;

endpackage

// [rtl/cdlut_table.sv]
// Colour depth conversion lookup table with its command loader.
// Assumes the host byte stream and pixel codes come from same-clock logic.
`timescale 1ns/1ps
`include "cdlut_cfg.svh"

module cdlut_table
  import cdlut_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            resetn,
  input  wire logic            byte_valid,
  input  cdlut_byte_type       byte_in,
  input  wire logic [2:0]      pixel_format,
  input  wire logic            pixel_valid,
  input  cdlut_code_type       pixel_code,
  output logic                 pixel_out_valid,
  output cdlut_pixel_type      pixel_out,
  output logic                 load_busy
);

  // ==========================================================
  // Defaults
  // ==========================================================
  // Code zero maps to zero, otherwise the code is scaled and
  // the low bits filled with ones
  function automatic logic [4:0] def5(input logic [3:0] code);
    def5 = (code == 4'h0) ? 5'h00 : {code, 1'b1};
  endfunction

  function automatic logic [5:0] def6(input logic [3:0] code);
    def6 = (code == 4'h0) ? 6'h00 : {code, 2'b11};
  endfunction

  // Masks a right aligned code down to the bits that a format
  // carries, so that the unused upper entries are never reached
  function automatic logic [3:0] narrow(input logic [3:0] code,
                                        input logic [3:0] keep);
    narrow = code & keep;
  endfunction

  // ==========================================================
  // Storage
  // ==========================================================
  logic [4:0] red_q   [`CDLUT_TONES];
  logic [5:0] green_q [`CDLUT_TONES];
  logic [4:0] blue_q  [`CDLUT_TONES];

  cdlut_state_type state_q;
  logic [5:0]      load_idx_q;

  // ==========================================================
  // Command decoder
  // ==========================================================
  // Byte classification shared by the decoder and the table writers
  logic cmd_seen;
  logic load_cmd_seen;
  logic load_byte;
  logic last_byte;

  assign cmd_seen      = byte_valid && byte_in.is_cmd;
  assign load_cmd_seen = cmd_seen && (byte_in.data == `CDLUT_CMD_LOAD);
  assign load_byte     = byte_valid && !byte_in.is_cmd &&
                         (state_q == CDLUT_LOADING);
  assign last_byte     = load_byte && (load_idx_q == `CDLUT_LOAD_LAST);

  // Decoder state. Any command word ends a load in progress, so a
  // short load leaves the later entries holding their previous
  // values; data bytes seen outside a load are simply ignored
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= CDLUT_IDLE;
    end else if (cmd_seen) begin
      if (load_cmd_seen) begin
        state_q <= CDLUT_LOADING;
      end else begin
        state_q <= CDLUT_OTHER;
      end
    end else begin
      case (state_q)
        CDLUT_LOADING: begin
          if (last_byte) begin
            state_q <= CDLUT_OTHER; // Extra bytes are dropped
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Tone index. It restarts on every command word, so a new load
  // always begins at the first red entry whatever came before
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      load_idx_q <= 6'h00;
    end else if (cmd_seen) begin
      load_idx_q <= 6'h00;
    end else if (load_byte) begin
      load_idx_q <= load_idx_q + 6'h01;
    end
  end

  // ==========================================================
  // Table writes
  // ==========================================================
  // Bytes are right aligned and their upper bits are ignored. Each
  // colour has a block of its own so that one range can never
  // spill into another
  logic       red_wr;
  logic       green_wr;
  logic       blue_wr;
  logic [3:0] tone_sel;

  assign red_wr   = load_byte && (load_idx_q < `CDLUT_GREEN_FIRST);
  assign green_wr = load_byte && (load_idx_q >= `CDLUT_GREEN_FIRST) &&
                    (load_idx_q < `CDLUT_BLUE_FIRST);
  assign blue_wr  = load_byte && (load_idx_q >= `CDLUT_BLUE_FIRST);
  assign tone_sel = 4'(load_idx_q); // Entry within the colour range

  // Red tones; hardware reset discards whatever the host loaded
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `CDLUT_TONES; i++) begin
        red_q[i] <= def5(4'(i));
      end
    end else if (red_wr) begin
      red_q[tone_sel] <= 5'(byte_in.data);
    end
  end

  // Green tones carry one bit more than red and blue
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `CDLUT_TONES; i++) begin
        green_q[i] <= def6(4'(i));
      end
    end else if (green_wr) begin
      green_q[tone_sel] <= 6'(byte_in.data);
    end
  end

  // Blue tones; in 256-colour mode only the first four are reachable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `CDLUT_TONES; i++) begin
        blue_q[i] <= def5(4'(i));
      end
    end else if (blue_wr) begin
      blue_q[tone_sel] <= 5'(byte_in.data);
    end
  end

  assign load_busy = (state_q == CDLUT_LOADING);

  // ==========================================================
  // Pixel conversion
  // ==========================================================
  // In 256-colour mode the upper code bits are masked so only
  // the low entries are reachable
  logic [3:0] r_idx;
  logic [3:0] g_idx;
  logic [3:0] b_idx;
  logic       lut_mode;

  always_comb begin
    lut_mode = 1'b1;
    r_idx    = pixel_code.red;
    g_idx    = pixel_code.green;
    b_idx    = pixel_code.blue;
    case (pixel_format)
      `CDLUT_FMT_256: begin
        r_idx = narrow(pixel_code.red, `CDLUT_KEEP_RG256);
        g_idx = narrow(pixel_code.green, `CDLUT_KEEP_RG256);
        b_idx = narrow(pixel_code.blue, `CDLUT_KEEP_B256);
      end
      `CDLUT_FMT_4096: begin
        r_idx = pixel_code.red;
        g_idx = pixel_code.green;
        b_idx = pixel_code.blue;
      end
      default: begin
        lut_mode = 1'b0;
      end
    endcase
  end

  // One take condition for both registers, so strobe and data can
  // never disagree about which pixel was converted
  logic pixel_take;

  assign pixel_take = pixel_valid && lut_mode;

  // Answer strobe: a single-cycle pulse after each converted pixel
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pixel_out_valid <= 1'b0;
    end else begin
      pixel_out_valid <= pixel_take;
    end
  end

  // Answer data. Other formats pass nothing through here, and the
  // last pixel stays on the outputs until the next one is converted
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pixel_out <= '0;
    end else if (pixel_take) begin
      pixel_out <= {red_q[r_idx], green_q[g_idx], blue_q[b_idx]};
    end
  end

endmodule

// [test/cdlut_table_properties.sv]
// Port checker for the colour table.
// Assumes a bind onto cdlut_table.
`timescale 1ns/1ps
module cdlut_props
  import cdlut_pkg::*;
(
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       byte_valid,
  input cdlut_byte_type  byte_in,
  input wire logic [2:0] pixel_format,
  input wire logic       pixel_valid,
  input cdlut_pixel_type pixel_out,
  input wire logic       pixel_out_valid,
  input wire logic       load_busy
);
  // ====================
  // Pixel and loader relations
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic tk, cm;
  assign tk = pixel_valid && pixel_format[2:1] == 2'b01;
  assign cm = byte_valid && byte_in.is_cmd;
  a_fmt256_answer: assert property (tk && pixel_format[0] == 1'b0 |=> pixel_out_valid) else $error("256 no answer");
  a_fmt4096_answer: assert property (tk && pixel_format[0] |=> pixel_out_valid) else $error("4096 no answer");
  a_no_answer: assert property (!tk |=> !pixel_out_valid) else $error("stray answer");
  a_out_holds: assert property (!pixel_out_valid |-> $stable(pixel_out)) else $error("output moved");
  a_load_enter: assert property (cm && byte_in.data == 8'h2d |=> load_busy) else $error("load not begun");
  a_cmd_abort: assert property (cm && byte_in.data != 8'h2d |=> !load_busy) else $error("load not ended");
  a_stray_data: assert property (!load_busy && !cm |=> !load_busy) else $error("data began load");
  a_busy_holds: assert property (load_busy && !byte_valid |=> load_busy) else $error("load lost");
endmodule
bind cdlut_table cdlut_props u_props (.clock(clock), .resetn(resetn),
  .byte_valid(byte_valid), .byte_in(byte_in), .pixel_format(pixel_format),
  .pixel_valid(pixel_valid), .pixel_out(pixel_out),
  .pixel_out_valid(pixel_out_valid), .load_busy(load_busy));

// [test/cdlut_host.sv]
// Host model: one table load, then a stray command.
// Assumes the table samples bytes on the rising edge.
`timescale 1ns/1ps
module cdlut_host
  import cdlut_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      start,
  output logic           byte_valid,
  output cdlut_byte_type byte_in,
  output logic           done
);
  // ====================
  // Tone k carries 63-k, so upper byte bits are set too. A mid-load
  // gap, one byte past the last tone and a closing command follow
  initial begin
    byte_valid = 1'b0;
    byte_in = 9'h000;
    done = 1'b0;
    @(posedge start);
    for (int k = -1; k < 50; k++) begin
      @(negedge clock);
      if (k == 24) begin
        byte_valid = 1'b0; // One idle cycle inside the load
        @(negedge clock);
      end
      byte_valid = 1'b1;
      byte_in = k < 0 ? 9'h12d : k > 48 ? 9'h100 : 9'(63 - k);
    end
    @(negedge clock);
    byte_valid = 1'b0;
    byte_in = ~byte_in; // Released bus shows no stale value
    done = 1'b1;
  end
endmodule

// [test/cdlut_table_tb_top.sv]
// Testbench for the colour table.
// Assumes the host model drives all byte traffic.
`timescale 1ns/1ps
module cdlut_table_tb_top;
  import cdlut_pkg::*;
  logic clock = 0, resetn = 0, pixel_valid = 0, start = 0;
  logic [2:0] pixel_format = 3'h0;
  cdlut_code_type pixel_code = 12'h000;
  logic byte_valid, pixel_out_valid, load_busy, done;
  cdlut_byte_type byte_in;
  cdlut_pixel_type pixel_out;
  int errors = 0, total_checks = 0;
  cdlut_table dut (.clock(clock), .resetn(resetn), .byte_valid(byte_valid),
    .byte_in(byte_in), .pixel_format(pixel_format),
    .pixel_valid(pixel_valid), .pixel_code(pixel_code),
    .pixel_out_valid(pixel_out_valid), .pixel_out(pixel_out),
    .load_busy(load_busy));
  cdlut_host host (.clock(clock), .start(start), .byte_valid(byte_valid),
    .byte_in(byte_in), .done(done));
  initial forever #5 clock = ~clock;
  // ====================
  // Checks; loaded tones are 31-x and 47-x
  task automatic chk(logic [16:0] got, logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [5:0] tn(logic [3:0] x, int s, bit l);
    return l ? 6'((s == 2 ? 31 : 47) - x) : x == 0 ? 6'h00 : 6'(x * s + s - 1);
  endfunction
  task automatic all_codes(bit l);
    logic [3:0] r, b;
    for (int f = 2; f < 4; f++) for (int j = 0; j < 16; j++) begin
      r = f == 2 ? 4'(j & 7) : 4'(j);
      b = f == 2 ? 4'(j & 3) : 4'(j);
      @(negedge clock);
      pixel_valid = 1'b1;
      pixel_format = 3'(f);
      pixel_code = {4'(j), 4'(j), 4'(j)};
      @(negedge clock);
      pixel_valid = 1'b0;
      chk({pixel_out_valid, pixel_out}, {1'b1, 5'(tn(r, 2, l)), tn(r, 4, l), 5'(tn(b, 2, l))});
    end
  endtask
  task automatic t_load;
    @(negedge clock) start = 1'b1;
    for (int i = 0; i < 80 && !done; i++) @(negedge clock);
    chk({done, load_busy}, 17'h2);
    all_codes(1);
  endtask
  task automatic t_reset;
    resetn = 1'b0;
    @(negedge clock);
    chk({pixel_out_valid, pixel_out}, 17'h0);
    resetn = 1'b1;
    all_codes(0);
  endtask
  // Other formats: no strobe, the code-fifteen default pixel stays
  task automatic t_bypass;
    for (int f = 0; f < 8; f++) begin
      if (f != 2 && f != 3) begin
        @(negedge clock);
        pixel_valid = 1'b1;
        pixel_format = 3'(f);
        pixel_code = 12'h000;
        @(negedge clock);
        pixel_valid = 1'b0;
        chk({pixel_out_valid, pixel_out}, 17'h0ffff);
      end
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    all_codes(0);
    t_bypass;
    t_load;
    t_reset;
    final_report;
  end
  initial begin
    #20000 errors++;
    final_report;
  end
endmodule
